// file: inc/frag_pkg.sv
// Constants for the flash rewrite access guard.
//Contract
//- Serial ID mismatch refuses all later commands
//- Erased reset vector skips ID compare
//- Seven stored ID bytes at fixed addresses
//- Recognise forced erase word byte values
//- Forced erase only in standard serial mode
//- Both IDs reserved: erase whole user area
//- Received reserved only: erase when field 11b
//- Stored reserved only: mismatch, no erase
//- Protection blocks parallel read and rewrite
//- Erasing protect block leaves byte erased
//- Protect byte 00h or FFh means disabled
//- CPU rewrite limited to user area only
//- In-flash mode refuses own block rewrite
//- In-flash mode has no status read
//- Mode after operation differs per mode
//- In-flash mode holds CPU during operation
//- Ready and error flags in both modes
//- Ready reads zero while operation executes
package frag_pkg;
  localparam int ID_BYTES = 7;
  localparam logic [19:0] ID_ADDR [ID_BYTES] = '{20'hF_FFDF, 20'hF_FFE3, 20'hF_FFEB,
    20'hF_FFEF, 20'hF_FFF3, 20'hF_FFF7, 20'hF_FFFB};
  localparam logic [7:0] ERASE_WORD [ID_BYTES] = '{8'h41, 8'h4C, 8'h65, 8'h52, 8'h41,
    8'h53, 8'h45};
  localparam logic [31:0] VEC_ERASED  = 32'hFFFF_FFFF;
  localparam logic [7:0]  BYTE_ERASED = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [1:0]  SEL_OFF     = 2'b11;
  localparam int          SEL_HI      = 7;
  localparam int          SEL_LO      = 6;
  typedef enum logic [1:0] {
    FRAG_IDLE  = 2'b00,
    FRAG_BUSY  = 2'b01
  } frag_op_e;
  typedef enum logic [1:0] {
    FRAG_ARRAY  = 2'b00,
    FRAG_STATUS = 2'b01
  } frag_rd_e;
endpackage

// file: src/frag_guard.sv
// Flash rewrite access guard: ID check, forced erase, protect and CPU modes.
`timescale 1ns/1ps
module frag_guard #(
  parameter int BLK_W = 4  // Block index width
) (
  input  wire logic             clk,            // 50 MHz clock
  input  wire logic             rst_n,          // Async reset, active low
  input  wire logic             ce,             // Clock enable
  input  wire logic             serial_mode,    // Standard serial mode active
  input  wire logic             parallel_mode,  // Parallel mode active
  input  wire logic             cpu_rewrite,    // CPU rewrite mode enabled
  input  wire logic             in_flash_mode,  // 1 in-flash, 0 external exec
  input  wire logic [31:0]      reset_vector,   // Stored reset vector bytes
  input  wire logic [7:0]       stored_id [7],  // Stored ID bytes, first lowest
  input  wire logic [7:0]       code_protect_byte, // Stored protect byte
  input  wire logic             id_valid,       // Received ID set strobe
  input  wire logic [7:0]       rx_id [7],      // Received ID bytes
  input  wire logic             cmd_valid,      // Programmer command strobe
  output logic                  cmd_accept,     // Programmer command taken
  output logic                  cmd_refuse,     // Programmer command refused
  output logic                  id_ok_ff,       // ID match state
  output logic                  forced_erase_ff,// Whole user area erase pulse
  input  wire logic             par_access,     // Parallel read/rewrite request
  output logic                  par_grant,      // Parallel access granted
  input  wire logic             cpu_op_req,     // CPU program/erase request
  input  wire logic             cpu_op_boot,    // Target is boot area
  input  wire logic [BLK_W-1:0] cpu_op_blk,     // Target block
  input  wire logic [BLK_W-1:0] code_blk,       // Block holding running code
  input  wire logic             stat_rd_req,    // Read status command
  output logic                  stat_rd_ok,     // Status read honoured
  output logic                  op_reject,      // CPU command rejected
  input  wire logic             op_done,        // Sequencer finished
  input  wire logic             op_prog_err,    // Program error at finish
  input  wire logic             op_erase_err,   // Erase error at finish
  input  wire logic             op_erase,       // Current op is erase
  input  wire logic             clear_status,   // Clear status command
  output logic                  op_start,       // Sequencer start pulse
  output logic                  flash_ready_flag,  // Ready flag
  output logic                  program_error_flag,// Program error flag
  output logic                  erase_error_flag,  // Erase error flag
  output logic [7:0]            status_byte,    // Ready/erase/program fail bits
  output logic                  status_mode_ff, // 1 status readout, 0 array
  output logic                  cpu_hold        // CPU held with ports frozen
);

  ////////////////////////////////////////////////////////////////////////////////
  // ID comparisons
  logic rx_res;
  logic st_res;
  logic id_eq;
  logic vec_blank;
  logic prot_on;
  always_comb
  begin
    rx_res = 1'b1;
    st_res = 1'b1;
    id_eq  = 1'b1;
    for (int i = 0; i < frag_pkg::ID_BYTES; i++)
    begin
      rx_res = rx_res & (rx_id[i] == frag_pkg::ERASE_WORD[i]);
      st_res = st_res & (stored_id[i] == frag_pkg::ERASE_WORD[i]);
      id_eq  = id_eq & (rx_id[i] == stored_id[i]);
    end
  end

  // Blank vector bypass and protect decode
  assign vec_blank = (reset_vector == frag_pkg::VEC_ERASED);
  assign prot_on = (code_protect_byte[frag_pkg::SEL_HI:frag_pkg::SEL_LO] != frag_pkg::SEL_OFF)
                 && (code_protect_byte != frag_pkg::BYTE_ZERO)
                 && (code_protect_byte != frag_pkg::BYTE_ERASED);

  logic do_erase;
  logic nxt_id_ok;
  // Erase only with reserved word received, never outside serial mode
  assign do_erase = serial_mode && id_valid && rx_res
                  && (st_res || !prot_on);
  assign nxt_id_ok = vec_blank || id_eq;

  ////////////////////////////////////////////////////////////////////////////////
  // ID result held until next transfer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      id_ok_ff <= 1'b0;
    else if (ce && serial_mode && id_valid)
      id_ok_ff <= nxt_id_ok;
  end

  // Forced erase pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      forced_erase_ff <= 1'b0;
    else if (ce)
      forced_erase_ff <= do_erase;
  end

  // Blank vector accepts even before any ID transfer
  assign cmd_accept = cmd_valid && serial_mode && (id_ok_ff || vec_blank);
  assign cmd_refuse = cmd_valid && serial_mode && !(id_ok_ff || vec_blank);
  assign par_grant  = par_access && parallel_mode && !prot_on;

  ////////////////////////////////////////////////////////////////////////////////
  // CPU rewrite command screening
  frag_pkg::frag_op_e op_ff;
  logic busy;
  logic bad_tgt;
  assign busy    = (op_ff == frag_pkg::FRAG_BUSY);
  assign bad_tgt = cpu_op_boot
                 || (in_flash_mode && (cpu_op_blk == code_blk));
  assign op_reject  = cpu_rewrite && cpu_op_req && (bad_tgt || busy);
  assign op_start   = cpu_rewrite && cpu_op_req && !bad_tgt && !busy && ce;
  assign stat_rd_ok = cpu_rewrite && stat_rd_req && !in_flash_mode;

  // Operation tracker
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      op_ff <= frag_pkg::FRAG_IDLE;
    else if (ce)
    begin
      unique case (op_ff)
        frag_pkg::FRAG_IDLE: if (op_start) op_ff <= frag_pkg::FRAG_BUSY;
        frag_pkg::FRAG_BUSY: if (op_done) op_ff <= frag_pkg::FRAG_IDLE;
        default:             op_ff <= frag_pkg::FRAG_IDLE;
      endcase
    end
  end

  assign flash_ready_flag = !busy;
  assign cpu_hold = busy && in_flash_mode;

  // Error flags; a new error beats a clear in the same cycle
  logic perr_ff;
  logic eerr_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      perr_ff <= 1'b0;
      eerr_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (busy && op_done && op_prog_err && !op_erase)
        perr_ff <= 1'b1;
      else if (clear_status)
        perr_ff <= 1'b0;
      if (busy && op_done && op_erase_err && op_erase)
        eerr_ff <= 1'b1;
      else if (clear_status)
        eerr_ff <= 1'b0;
    end
  end
  assign program_error_flag = perr_ff;
  assign erase_error_flag   = eerr_ff;
  assign status_byte = {flash_ready_flag, 1'b0, eerr_ff, perr_ff, 4'h0};

  // Read mode after finish
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_mode_ff <= 1'b0;
    else if (ce && busy && op_done)
      status_mode_ff <= !in_flash_mode;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  // No command taken without a match
  a_id_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_valid && serial_mode && !vec_blank && !id_ok_ff) |-> !cmd_accept)
    else $error("command accepted without ID match");

  // Unmatched command is refused
  a_id_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_valid && serial_mode && !vec_blank && !id_ok_ff) |-> cmd_refuse)
    else $error("unmatched command not refused");

  // Accept and refuse never together
  a_cmd_excl: assert property (@(posedge clk) disable iff (!rst_n)
    !(cmd_accept && cmd_refuse))
    else $error("command both accepted and refused");

  // Programmer answers only in serial mode
  a_cmd_serial: assert property (@(posedge clk) disable iff (!rst_n)
    !serial_mode |-> (!cmd_accept && !cmd_refuse))
    else $error("command answered outside serial mode");

  // Differing ID clears the match
  a_id_miss: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && serial_mode && id_valid && !vec_blank && !id_eq) |=> !id_ok_ff)
    else $error("mismatching ID matched");

  // Equal ID sets the match
  a_id_match: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && serial_mode && id_valid && id_eq) |=> id_ok_ff)
    else $error("equal ID not matched");

  // Blank vector takes every command
  a_blank_vec: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd_valid && serial_mode && vec_blank) |-> cmd_accept)
    else $error("blank vector command refused");

  // Blank vector makes any transfer a match
  a_blank_id: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && serial_mode && id_valid && vec_blank) |=> id_ok_ff)
    else $error("blank vector transfer not matched");

  // Match only moves on a transfer
  a_id_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(ce && serial_mode && id_valid) |=> $stable(id_ok_ff))
    else $error("ID result changed without transfer");

  // Enable low freezes registered state
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> ($stable(id_ok_ff) && $stable(forced_erase_ff) && $stable(status_mode_ff)
             && $stable(program_error_flag) && $stable(erase_error_flag)))
    else $error("state moved while clock enable low");

  // Forced erase never outside serial mode
  a_erase_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !serial_mode) |=> !forced_erase_ff)
    else $error("forced erase outside serial mode");

  // Reserved word on both sides erases
  a_erase_both: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && serial_mode && id_valid && rx_res && st_res) |=> forced_erase_ff)
    else $error("forced erase missed");

  // Protection turns a lone reserved word into a check
  a_erase_prot: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && id_valid && !st_res && prot_on) |=> !forced_erase_ff)
    else $error("forced erase while protected");

  // Unprotected part erases on received word alone
  a_erase_open: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && serial_mode && id_valid && rx_res && !prot_on) |=> forced_erase_ff)
    else $error("unprotected forced erase missed");

  // Stored word alone is a plain mismatch
  a_stored_only: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && serial_mode && id_valid && !vec_blank && st_res && !rx_res)
    |=> (!forced_erase_ff && !id_ok_ff))
    else $error("stored reserved word misused");

  // Only the exact reserved word may erase
  a_erase_word: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && serial_mode && id_valid && !rx_res) |=> !forced_erase_ff)
    else $error("forced erase on other word");

  // Erase pulse needs a transfer
  a_erase_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !id_valid) |=> !forced_erase_ff)
    else $error("forced erase without transfer");

  // Protection blocks parallel access
  a_par_block: assert property (@(posedge clk) disable iff (!rst_n)
    prot_on |-> !par_grant)
    else $error("parallel access while protected");

  // No grant outside parallel mode
  a_par_mode: assert property (@(posedge clk) disable iff (!rst_n)
    !parallel_mode |-> !par_grant)
    else $error("grant outside parallel mode");

  // Erased or cleared byte leaves access open
  a_par_open: assert property (@(posedge clk) disable iff (!rst_n)
    (par_access && parallel_mode && ((code_protect_byte == frag_pkg::BYTE_ERASED)
     || (code_protect_byte == frag_pkg::BYTE_ZERO))) |-> par_grant)
    else $error("disabled protect byte blocked access");

  // Field off leaves access open
  a_par_field: assert property (@(posedge clk) disable iff (!rst_n)
    (par_access && parallel_mode
     && (code_protect_byte[frag_pkg::SEL_HI:frag_pkg::SEL_LO] == frag_pkg::SEL_OFF))
    |-> par_grant)
    else $error("protect field off blocked access");

  // Boot area never rewritten by CPU
  a_boot_rej: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_op_boot && cpu_op_req && cpu_rewrite) |-> (op_reject && !op_start))
    else $error("boot area rewrite taken");

  // Own block protected in in-flash mode
  a_self_blk: assert property (@(posedge clk) disable iff (!rst_n)
    (in_flash_mode && cpu_op_req && cpu_op_blk == code_blk) |-> !op_start)
    else $error("own block rewrite taken");

  // External mode may hit any user block
  a_ext_blk: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && cpu_rewrite && cpu_op_req && !in_flash_mode && !cpu_op_boot && !busy)
    |-> op_start)
    else $error("legal user block request lost");

  // A busy sequencer turns requests away
  a_busy_rej: assert property (@(posedge clk) disable iff (!rst_n)
    (busy && cpu_op_req && cpu_rewrite) |-> (op_reject && !op_start))
    else $error("request taken while busy");

  // No status read in in-flash mode
  a_no_stat: assert property (@(posedge clk) disable iff (!rst_n)
    in_flash_mode |-> !stat_rd_ok)
    else $error("status read in in-flash mode");

  // Status read honoured in external mode
  a_ext_stat: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_rewrite && stat_rd_req && !in_flash_mode) |-> stat_rd_ok)
    else $error("status read refused in external mode");

  // Read mode follows the rewrite mode at finish
  a_mode_after: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && busy && op_done) |=> (status_mode_ff == !$past(in_flash_mode)))
    else $error("wrong read mode after operation");

  // Read mode stays between finishes
  a_mode_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !(busy && op_done)) |=> $stable(status_mode_ff))
    else $error("read mode changed without finish");

  // Start drops ready and holds CPU in in-flash mode
  a_ready_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && op_start) |=> (!flash_ready_flag && (cpu_hold == in_flash_mode)))
    else $error("ready or hold wrong after start");

  // Finish brings ready back
  a_ready_done: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && busy && op_done) |=> flash_ready_flag)
    else $error("ready not back after finish");

  // CPU keeps running in external mode
  a_hold_ext: assert property (@(posedge clk) disable iff (!rst_n)
    !in_flash_mode |-> !cpu_hold)
    else $error("CPU held in external mode");

  // Program error latched at finish
  a_perr_set: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && busy && op_done && op_prog_err && !op_erase) |=> program_error_flag)
    else $error("program error lost");

  // Erase error latched at finish
  a_eerr_set: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && busy && op_done && op_erase_err && op_erase) |=> erase_error_flag)
    else $error("erase error lost");

  // Clear empties both flags when no finish competes
  a_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && clear_status && !(busy && op_done))
    |=> (!program_error_flag && !erase_error_flag))
    else $error("error flags survived clear");

  // Program error stands until cleared
  a_err_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !clear_status && program_error_flag) |=> program_error_flag)
    else $error("program error dropped without clear");

endmodule // frag_guard

// file: testbench/frag_seq_model.sv
// Flash sequencer model that answers each start pulse after a delay.
`timescale 1ns/1ps
module frag_seq_model (
  input  wire logic clk,   // 50 MHz clock
  input  wire logic rst_n, // Async reset, active low
  input  wire logic start, // Sequencer start pulse
  input  wire logic slow,  // Long operation wanted
  output logic      done   // One-cycle finish pulse
);
  logic [4:0] cnt_ff;
  // Down-counter; slow runs keep the block busy long enough to see ready low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 5'h0;
      done   <= 1'b0;
    end
    else
    begin
      done   <= (cnt_ff == 5'h1);
      cnt_ff <= start ? (slow ? 5'h14 : 5'h2) : (cnt_ff != 5'h0) ? cnt_ff - 5'h1 : 5'h0;
    end
  end
endmodule // frag_seq_model

// file: testbench/frag_guard_tb.sv
// Self-checking bench for the flash rewrite access guard.
`timescale 1ns/1ps
module frag_guard_tb;
  logic        clk, rst_n, sm, pm, cr, ifm, idv, cmv, pa, req, boot, srq, perr, clr, slow;
  logic        eerr, oer, ce_i, eef;
  logic        acc, rfs, iok, fe, pg, ost, rok, rej, done, rdy, pef, smd, hold;
  logic [31:0] vec, rs;
  logic [7:0]  sid [7], rid [7], cpb, sb, b;
  logic [3:0]  blk, cblk;
  int          err_count, checks_done, i;
  frag_guard dut (.clk(clk), .rst_n(rst_n), .ce(ce_i), .serial_mode(sm), .parallel_mode(pm),
    .cpu_rewrite(cr), .in_flash_mode(ifm), .reset_vector(vec), .stored_id(sid),
    .code_protect_byte(cpb), .id_valid(idv), .rx_id(rid), .cmd_valid(cmv), .cmd_accept(acc),
    .cmd_refuse(rfs), .id_ok_ff(iok), .forced_erase_ff(fe), .par_access(pa), .par_grant(pg),
    .cpu_op_req(req), .cpu_op_boot(boot), .cpu_op_blk(blk), .code_blk(cblk),
    .stat_rd_req(srq), .stat_rd_ok(rok), .op_reject(rej), .op_done(done),
    .op_prog_err(perr), .op_erase_err(eerr), .op_erase(oer), .clear_status(clr),
    .op_start(ost), .flash_ready_flag(rdy), .program_error_flag(pef), .erase_error_flag(eef),
    .status_byte(sb), .status_mode_ff(smd), .cpu_hold(hold));
  frag_seq_model seq (.clk(clk), .rst_n(rst_n), .start(ost), .slow(slow), .done(done));
  ////////////////////////////////////////////////////////////////////////////////
  // Xorshift source and expectation helpers
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic exp_grant(input logic [7:0] v);
    return (v == 8'h00) || (v == 8'hFF) || (v[7:6] == 2'b11);
  endfunction
  task automatic chk(input logic a, input logic e);
    checks_done++;
    if (a !== e)
    begin
      $display("unexpected at %0t: output mismatch", $time);
      err_count++;
    end
  endtask
  // One ID transfer; stored and received bytes change with the strobe
  task automatic id_xfer(input logic rr, input logic sr, input logic same);
    logic [31:0] v;
    @(posedge clk);
    for (int k = 0; k < 7; k++)
    begin
      v = xs();
      sid[k] <= sr ? frag_pkg::ERASE_WORD[k] : v[7:0];
      rid[k] <= rr ? frag_pkg::ERASE_WORD[k] : (same ? v[7:0] : ~v[7:0]);
    end
    idv <= 1'b1;
    @(posedge clk);
    idv <= 1'b0;
    @(negedge clk);
  endtask
  task automatic cmd(input logic e);
    @(posedge clk);
    cmv <= 1'b1;
    @(negedge clk);
    chk(acc, e);
    chk(rfs, !e);
    @(posedge clk);
    cmv <= 1'b0;
  endtask
  // CPU request; an accepted one is followed to completion under a bound
  task automatic op(input logic bt, input logic [3:0] tb, input logic e);
    @(posedge clk);
    req  <= 1'b1;
    boot <= bt;
    blk  <= tb;
    @(negedge clk);
    chk(ost, e);
    chk(rej, !e);
    @(posedge clk);
    req <= 1'b0;
    if (e)
    begin
      @(negedge clk);
      chk(rdy, 1'b0);
      chk(hold, ifm);
      for (int k = 0; k < 60 && done !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      chk(rdy, 1'b1);
      chk(smd, !ifm);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the run needs well under a tenth of the limit
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #200_000;
    err_count++;
    final_report();
  end
  // Main sequence
  initial
  begin
    {rst_n, sm, pm, cr, ifm, idv, cmv, pa, req, boot, srq, perr, clr, slow} = '0;
    {eerr, oer} = 2'b00;
    ce_i = 1'b1;
    vec = 32'h1234_5678; rs = 32'h0001_60AF; cpb = 8'hBF; blk = 4'h0; cblk = 4'h3;
    err_count = 0; checks_done = 0;
    for (int k = 0; k < 7; k++) begin sid[k] = 8'h00; rid[k] = 8'h00; end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    sm    <= 1'b1;
    @(negedge clk);
    chk(rdy, 1'b1);
    chk(iok, 1'b0);
    chk(pef, 1'b0);
    id_xfer(1'b0, 1'b0, 1'b1); chk(iok, 1'b1);
    cmd(1'b1);
    cmd(1'b1);
    // Mid-run reset drops the earlier match
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    @(negedge clk) chk(iok, 1'b0);
    id_xfer(1'b0, 1'b0, 1'b0); cmd(1'b0);
    // Enable low must freeze the match state
    @(posedge clk) ce_i <= 1'b0;
    id_xfer(1'b0, 1'b0, 1'b1); chk(iok, 1'b0);
    @(posedge clk) ce_i <= 1'b1;
    @(posedge clk) vec <= frag_pkg::VEC_ERASED;
    cmd(1'b1);
    @(posedge clk) vec <= 32'h1234_5678;
    id_xfer(1'b1, 1'b1, 1'b0); chk(fe, 1'b1);
    @(negedge clk) chk(fe, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk) cpb <= {i[1:0], 6'h3F};
      id_xfer(1'b1, 1'b0, 1'b0); chk(fe, i == 3);
    end
    @(posedge clk) cpb <= 8'hBF;
    id_xfer(1'b0, 1'b1, 1'b0); chk(fe, 1'b0); cmd(1'b0);
    @(posedge clk) sm <= 1'b0;
    id_xfer(1'b1, 1'b1, 1'b0); chk(fe, 1'b0);
    for (i = 0; i < 10; i++)
    begin
      b = (i < 5) ? 40'h3F_00FF_BF7F >> (8 * i) : xs();
      @(posedge clk) {cpb, pa, pm} <= {b, 2'b11};
      @(negedge clk) chk(pg, exp_grant(b));
    end
    @(posedge clk) {pa, pm, cr, ifm, srq} <= 5'b00111;
    @(negedge clk) chk(rok, 1'b0);
    @(posedge clk) ifm <= 1'b0;
    @(negedge clk) chk(rok, 1'b1);
    @(posedge clk) {srq, ifm} <= 2'b01;
    op(1'b1, 4'h0, 1'b0);
    op(1'b0, 4'h3, 1'b0);
    @(posedge clk) perr <= 1'b1;
    op(1'b0, 4'h5, 1'b1);
    chk(pef, 1'b1); chk(sb[4], 1'b1); chk(sb[7], 1'b1);
    // Erase with both error inputs high: only the erase flag may set
    @(posedge clk) {perr, eerr, oer} <= 3'b111;
    op(1'b0, 4'h6, 1'b1);
    chk(eef, 1'b1); chk(sb[5], 1'b1); chk(pef, 1'b1);
    @(posedge clk) {perr, eerr, oer, clr} <= 4'b0001;
    @(posedge clk) clr <= 1'b0;
    @(negedge clk) chk(pef, 1'b0); chk(eef, 1'b0);
    @(posedge clk) {ifm, slow} <= 2'b01;
    op(1'b0, 4'h3, 1'b1);
    final_report();
  end
endmodule // frag_guard_tb
